// [rtl/spi_slave_select_pkg.sv]
// shared constants and types for the select-synchronised serial port
package spi_slave_select_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] BUF_ADDR    = 8'h08;
    localparam logic [7:0] IRQ_ADDR    = 8'h0C;
    localparam logic [7:0] MASK_ADDR   = 8'h10;
    localparam logic [7:0] SLEEP_ADDR  = 8'h14;

    // control register fields
    localparam int MODE_LSB        = 0;
    localparam int IDLE_POL_BIT    = 4;
    localparam int ENABLE_BIT      = 5;
    localparam int CLK_EDGE_BIT    = 6;
    localparam int SAMPLE_BIT      = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // port mode codes
    localparam logic [3:0] MODE_MASTER     = 4'h0;
    localparam logic [3:0] MODE_SLAVE_SEL  = 4'h4;
    localparam logic [3:0] MODE_SLAVE_FREE = 4'h5;

    // status fields
    localparam int BUF_FULL_BIT    = 0;
    localparam int COLLISION_BIT   = 1;
    localparam int OVERFLOW_BIT    = 2;
    localparam int SELECT_BIT      = 3;

    // interrupt status bits
    localparam int IRQ_BYTE_BIT    = 0;
    localparam int IRQ_SEL_BIT     = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
    localparam logic [5:0] MASTER_DIV      = 6'h04;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic sclk;
        logic selN;
        logic mosi;
    } link_in_t;

    typedef struct packed {
        logic sclkOut;
        logic sclkOe;
        logic misoOut;
        logic misoOe;
    } link_out_t;

    typedef enum logic [1:0] {
        IDLE,
        SHIFT,
        FROZEN
    } shift_state_t;

endpackage : spi_slave_select_pkg

// [rtl/spi_slave_select_sync.sv]
// serial port in spi mode with slave select synchronisation
// Function
// - select-gated slave operation only when port mode field equals 0100
// - select low in that mode enables shifting and drives the data output
// - select rising floats the data output after about three clock cycles of synchroniser lag, even mid byte
// - select high resets the serial module, realigning a slave that slipped
// - module reset clears bit counter; caused by select high or enable clear
// - slave shifts from external clock even in sleep, flags after eight bits
// - master sleep freezes the transfer; it resumes where it stopped
// - msb first; full byte moves to buffer, sets buffer full and flag
`timescale 1ns/100ps
module spi_slave_select_sync
    import spi_slave_select_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire link_in_t    linkIn,
    output link_out_t        linkOut,
    output logic             irq,
    output logic             wake
);

    logic [7:0]   ctrl_r;
    logic [7:0]   irqMask_r;
    logic [1:0]   irqStat_r;
    logic         sleep_r;
    logic [7:0]   shift_r;
    logic [7:0]   rxBuf_r;
    logic [2:0]   bitCnt_r;
    logic         bufFull_r;
    logic         collision_r;
    logic         overflow_r;
    shift_state_t state_r;
    logic [2:0]   sclkSync_r;
    logic [2:0]   selSync_r;
    logic [1:0]   mosiSync_r;
    logic [5:0]   divCnt_r;
    logic         mClk_r;
    logic         sampleBit_r;

    // synchronisers: stage 0 feeds only stage 1
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclkSync_r <= 3'h0;
            selSync_r  <= 3'h7;
            mosiSync_r <= 2'h0;
        end else begin
            sclkSync_r <= {sclkSync_r[1:0], linkIn.sclk};
            selSync_r  <= {selSync_r[1:0], linkIn.selN};
            mosiSync_r <= {mosiSync_r[0], linkIn.mosi};
        end
    end

    logic [3:0] mode;
    logic       enabled;
    logic       slaveMode;
    logic       selCtrl;
    logic       selHigh;
    logic       selFall;
    logic       idlePol;
    logic       edgeSel;
    logic       sclkRise;
    logic       sclkFall;
    logic       leadEdge;
    logic       trailEdge;
    logic       masterMode;
    logic       masterTick;
    logic       sampleEdge;
    logic       shiftEdge;
    logic       moduleReset;
    logic       byteDone;
    logic       serIn;

    assign mode       = ctrl_r[MODE_LSB +: 4];
    assign enabled    = ctrl_r[ENABLE_BIT];
    assign idlePol    = ctrl_r[IDLE_POL_BIT];
    assign edgeSel    = ctrl_r[CLK_EDGE_BIT];
    assign masterMode = enabled && (mode == MODE_MASTER);
    assign slaveMode  = enabled && (mode == MODE_SLAVE_SEL
                                    || mode == MODE_SLAVE_FREE);
    assign selCtrl    = enabled && (mode == MODE_SLAVE_SEL);
    // stage 1, as the data output enable uses: the falling edge cycle
    // must not still be held in module reset, or no byte ever starts
    assign selHigh    = selCtrl && selSync_r[1];
    assign selFall    = selSync_r[2] && !selSync_r[1];
    // edges compare stage 1 with stage 2, in step with the data stage
    assign sclkRise   = sclkSync_r[1] && !sclkSync_r[2];
    assign sclkFall   = !sclkSync_r[1] && sclkSync_r[2];
    // leading edge leaves idle level, trailing edge returns to it
    assign leadEdge   = idlePol ? sclkFall : sclkRise;
    assign trailEdge  = idlePol ? sclkRise : sclkFall;
    assign serIn      = mosiSync_r[1];
    // divider tick: sleep stops it, freezing a master transfer
    // limitation: fixed ratio, no programmable bit rate
    assign masterTick = masterMode && !sleep_r
                        && (divCnt_r == MASTER_DIV);
    // clock edge bit set: sample on leading, shift on trailing
    assign sampleEdge = slaveMode ? (edgeSel ? leadEdge : trailEdge)
                                  : (masterTick && mClk_r == idlePol);
    assign shiftEdge  = slaveMode ? (edgeSel ? trailEdge : leadEdge)
                                  : (masterTick && mClk_r != idlePol);
    assign moduleReset = !enabled || selHigh;
    assign byteDone   = (state_r == SHIFT) && shiftEdge
                        && (bitCnt_r == 3'h7);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            divCnt_r <= 6'h00;
            mClk_r   <= 1'b0;
        end else if (!masterMode || state_r == IDLE) begin
            divCnt_r <= 6'h00;
            mClk_r   <= idlePol;
        end else if (!sleep_r) begin
            divCnt_r <= masterTick ? 6'h00 : divCnt_r + 6'h01;
            if (masterTick) begin
                mClk_r <= !mClk_r;
            end
        end
    end

    // bus write handshake: address and data taken in either order
    logic        awHeld_r;
    logic        wHeld_r;
    logic [7:0]  awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        doWrite;
    logic        bufWrite;
    logic        bufRead;

    assign doWrite  = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign bufWrite = doWrite && awAddr_r == BUF_ADDR && wStrb_r[0];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            awHeld_r      <= 1'b0;
            wHeld_r       <= 1'b0;
            awAddr_r      <= 8'h00;
            wData_r       <= 32'h0;
            wStrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_r > SLEEP_ADDR
                                 || awAddr_r[1:0] != 2'h0)
                                ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_r    <= CTRL_RESET;
            irqMask_r <= 8'h00;
            sleep_r   <= 1'b0;
        end else if (doWrite && wStrb_r[0]) begin
            case (awAddr_r)
                CTRL_ADDR:  ctrl_r    <= wData_r[7:0];
                MASK_ADDR:  irqMask_r <= wData_r[7:0];
                SLEEP_ADDR: sleep_r   <= wData_r[0];
                default: ;
            endcase
        end
    end

    // shift engine; sleep does not stop slave shifting
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r     <= IDLE;
            bitCnt_r    <= BIT_COUNT_RESET;
            shift_r     <= 8'h00;
            sampleBit_r <= 1'b0;
        end else begin
            if (moduleReset) begin
                bitCnt_r <= BIT_COUNT_RESET;
                state_r  <= IDLE;
            end
            // a slave is loaded while deselected, so module reset must not
            // swallow the write; it only realigns the counter
            if (bufWrite && state_r == IDLE) begin
                shift_r <= wData_r[7:0];
                state_r <= masterMode ? SHIFT : IDLE;
            end
            if (!moduleReset && slaveMode && state_r == IDLE
                && (!selCtrl || selFall)) begin
                state_r  <= SHIFT;
                bitCnt_r <= BIT_COUNT_RESET;
            end
            if (!moduleReset && state_r == SHIFT) begin
                if (sampleEdge) begin
                    sampleBit_r <= serIn;
                end
                if (shiftEdge) begin
                    shift_r  <= {shift_r[6:0], sampleBit_r};
                    bitCnt_r <= bitCnt_r + 3'h1;
                    if (bitCnt_r == 3'h7 && masterMode) begin
                        state_r <= IDLE;
                    end
                end
            end
        end
    end

    // buffer; a new byte wins over a same-cycle read clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rxBuf_r     <= 8'h00;
            bufFull_r   <= 1'b0;
            overflow_r  <= 1'b0;
            collision_r <= 1'b0;
        end else begin
            if (byteDone) begin
                rxBuf_r   <= {shift_r[6:0], sampleBit_r};
                bufFull_r <= 1'b1;
                if (bufFull_r) begin
                    overflow_r <= 1'b1;
                end
            end else if (bufRead) begin
                bufFull_r <= 1'b0;
            end
            if (bufWrite && state_r == SHIFT) begin
                collision_r <= 1'b1;
            end else if (doWrite && awAddr_r == STATUS_ADDR
                         && wStrb_r[0]) begin
                if (wData_r[COLLISION_BIT]) begin
                    collision_r <= 1'b0;
                end
                // a new overflow in the same cycle wins over the clear
                if (wData_r[OVERFLOW_BIT] && !(byteDone && bufFull_r)) begin
                    overflow_r <= 1'b0;
                end
            end
        end
    end

    // sticky events, write one to clear, set wins
    logic [1:0] irqEvents;
    assign irqEvents = {selCtrl && selFall, byteDone};

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irqStat_r <= IRQ_RESET;
            irq       <= 1'b0;
            wake      <= 1'b0;
        end else begin
            if (doWrite && awAddr_r == IRQ_ADDR && wStrb_r[0]) begin
                irqStat_r <= (irqStat_r & ~wData_r[1:0]) | irqEvents;
            end else begin
                irqStat_r <= irqStat_r | irqEvents;
            end
            irq  <= |(irqStat_r & irqMask_r[1:0]);
            wake <= sleep_r && irqStat_r[IRQ_BYTE_BIT]
                    && irqMask_r[IRQ_BYTE_BIT];
        end
    end

    // read channel
    // buffer read clears full at the address handshake, not at rready
    assign bufRead = s_axi_arvalid && s_axi_arready && s_axi_araddr == BUF_ADDR;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                case (s_axi_araddr)
                    CTRL_ADDR:   s_axi_rdata <= {24'h0, ctrl_r};
                    STATUS_ADDR: s_axi_rdata <= {28'h0, selSync_r[2],
                                     overflow_r, collision_r, bufFull_r};
                    BUF_ADDR:    s_axi_rdata <= {24'h0, rxBuf_r};
                    IRQ_ADDR:    s_axi_rdata <= {30'h0, irqStat_r};
                    MASK_ADDR:   s_axi_rdata <= {24'h0, irqMask_r};
                    SLEEP_ADDR:  s_axi_rdata <= {31'h0, sleep_r};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // pins: output floats the cycle after stage 1 sees select high
    // lag: about three clock cycles of drive after select rises
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            linkOut <= '0;
        end else begin
            linkOut.misoOut <= shift_r[7];
            linkOut.misoOe  <= masterMode
                || (slaveMode && !(selCtrl && selSync_r[1]));
            linkOut.sclkOut <= masterMode ? mClk_r : idlePol;
            linkOut.sclkOe  <= masterMode;
        end
    end

endmodule : spi_slave_select_sync

// [sim/spi_slave_select_assertions.sv]
// concurrent checks on the select-synchronised serial port
`timescale 1ns/100ps
module spi_slave_select_checker
    import spi_slave_select_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire link_in_t    linkIn,
    input wire link_out_t   linkOut,
    input wire logic        irq,
    input wire logic        wake
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // select synchroniser lag allows a few cycles of drive
    chk_float_deselect: assert property (
        linkIn.selN [*5] |-> !linkOut.misoOe)
        else $error("data output driven while deselected");
    chk_wake_needs_irq: assert property (
        wake |-> irq)
        else $error("wake without pending interrupt");
    chk_reset_quiet: assert property (
        disable iff (1'b0) reset |=> !irq && !linkOut.misoOe
            && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write answer missing");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
            && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
            && $stable(s_axi_rdata))
        else $error("read data dropped early");
    // only master mode drives the clock, and it drives data with it
    chk_clock_with_data: assert property (
        !linkOut.misoOe |-> !linkOut.sclkOe)
        else $error("shift clock driven while data output floats");

    cover property ($rose(irq));
    cover property ($rose(linkOut.sclkOe));
    cover property ($rose(wake));
    cover property ($fell(linkOut.misoOe));
endmodule : spi_slave_select_checker

bind spi_slave_select_sync spi_slave_select_checker chk (
    .ref_clk(ref_clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .linkIn(linkIn), .linkOut(linkOut),
    .irq(irq), .wake(wake));

// [sim/spi_master_model.sv]
// behavioural spi master driving select, clock and data
`timescale 1ns/100ps
module spi_master_model (
    input  wire logic  miso,
    output logic       sclk,
    output logic       selN,
    output logic       mosi,
    output logic [7:0] rxByte
);
    initial begin
        sclk = 1'b0;
        selN = 1'b1;
        mosi = 1'b0;
        rxByte = 8'h00;
    end
    // short frames model a master that slipped bits
    task automatic xfer(input logic [7:0] txByte, input int nBits,
                        input int half);
        #1330 selN = 1'b0;
        for (int i = 7; i > 7 - nBits; i--) begin
            mosi = txByte[i];
            #half sclk = 1'b1;
            rxByte = {rxByte[6:0], miso};
            #half sclk = 1'b0;
        end
        #half selN = 1'b1;
        mosi = ~mosi;
    endtask : xfer
    // fixed levels for scenarios where the block makes the clock
    task automatic hold_lines(input logic sel, input logic level);
        selN = sel;
        mosi = level;
    endtask : hold_lines
endmodule : spi_master_model

// [sim/spi_slave_select_sync_bench.sv]
// self-checking bench for the select-synchronised serial port
`timescale 1ns/100ps
module spi_slave_select_sync_bench
    import spi_slave_select_pkg::*;
;
    logic ref_clk, reset, awValid, wValid, bReady, arValid, rReady;
    logic awReady, wReady, bValid, arReady, rValid, irq, wake;
    logic sclk, selN, mosi;
    logic [7:0]  awAddr, arAddr, tx, rep;
    logic [31:0] wData, rData;
    logic [1:0]  bResp, rResp;
    link_out_t   lo;
    logic [33:0] expQ[$], maskQ[$];
    int          errors, checked, cycles;
    wire logic   misoWire = lo.misoOe ? lo.misoOut : ~lo.misoOut;
    localparam logic [31:0] CTRL_VAL = 32'(MODE_SLAVE_SEL)
        | (32'h1 << ENABLE_BIT) | (32'h1 << CLK_EDGE_BIT);

    spi_slave_select_sync dut (
        .ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .linkIn({sclk, selN, mosi}),
        .linkOut(lo), .irq(irq), .wake(wake));
    spi_master_model master (.miso(misoWire), .sclk(sclk), .selN(selN),
        .mosi(mosi), .rxByte(rep));

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(aw && w)) begin
            @(posedge ref_clk);
            if (awValid && awReady) begin
                aw = 1'b1;
                awValid <= 1'b0;
            end
            if (wValid && wReady) begin
                w = 1'b1;
                wValid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (bValid !== 1'b1);
        bReady <= 1'b0;
        check({32'h0, bResp}, {32'h0, r});
        @(posedge ref_clk);
    endtask : axi_write
    // expected response and data are queued for the watcher
    task automatic axi_read(input logic [7:0] a, input logic [33:0] e,
                            input logic [33:0] m);
        expQ.push_back(e);
        maskQ.push_back(m);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge ref_clk); while (arReady !== 1'b1);
        arValid <= 1'b0;
        do @(posedge ref_clk); while (rValid !== 1'b1);
        rReady <= 1'b0;
        @(posedge ref_clk);
    endtask : axi_read
    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (irq !== e && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        check({33'h0, irq}, {33'h0, e});
    endtask : wait_irq

    always @(posedge ref_clk) begin
        if (rValid && rReady && expQ.size() > 0)
            check({rResp, rData} & maskQ.pop_front(), expQ.pop_front());
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        {awValid, wValid, bReady, arValid, rReady} = '0;
        {awAddr, arAddr, wData} = '0;
        {errors, checked, cycles} = '0;
        reset = 1'b1;
        void'($urandom(32'h3F0B1813));
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        axi_read(CTRL_ADDR, {RESP_OKAY, 24'h0, CTRL_RESET}, '1);
        axi_read(STATUS_ADDR, 34'h8, 34'h9);
        axi_read(8'h18, {RESP_SLVERR, 32'h0}, '1);
        axi_write(8'h1C, 32'h1, RESP_SLVERR);
        axi_write(CTRL_ADDR, CTRL_VAL, RESP_OKAY);
        axi_write(MASK_ADDR, 32'h1, RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            tx = 8'($urandom);
            axi_write(BUF_ADDR, {24'h0, ~tx}, RESP_OKAY);
            master.xfer(tx, 8, 400);
            check({26'h0, rep}, {26'h0, ~tx});
            wait_irq(1'b1);
            axi_read(STATUS_ADDR, 34'h1, 34'h1);
            axi_read(BUF_ADDR, {26'h0, tx}, 34'hFF);
            axi_read(STATUS_ADDR, 34'h0, 34'h1);
            axi_write(IRQ_ADDR, 32'h3, RESP_OKAY);
            wait_irq(1'b0);
            master.xfer(8'($urandom), 3, 400);
            axi_read(IRQ_ADDR, 34'h0, 34'h1);
        end
        axi_write(SLEEP_ADDR, 32'h1, RESP_OKAY);
        axi_write(MASK_ADDR, 32'h0, RESP_OKAY);
        master.xfer(tx, 8, 400);
        wait_irq(1'b0);
        axi_write(MASK_ADDR, 32'h1, RESP_OKAY);
        wait_irq(1'b1);
        check({33'h0, wake}, 34'h1);
        axi_read(BUF_ADDR, {26'h0, tx}, 34'hFF);
        // master mode: a byte loaded while asleep waits, then resumes
        axi_write(IRQ_ADDR, 32'h3, RESP_OKAY);
        axi_write(CTRL_ADDR, 32'h0, RESP_OKAY);
        master.hold_lines(1'b0, 1'b1);
        axi_write(CTRL_ADDR, 32'(MODE_MASTER) | (32'h1 << ENABLE_BIT),
                  RESP_OKAY);
        axi_write(BUF_ADDR, {24'h0, tx}, RESP_OKAY);
        repeat (40) @(posedge ref_clk);
        check({32'h0, lo.sclkOe, lo.sclkOut}, 34'h2);
        check({33'h0, irq}, 34'h0);
        axi_write(SLEEP_ADDR, 32'h0, RESP_OKAY);
        wait_irq(1'b1);
        axi_read(BUF_ADDR, {26'h0, 8'hFF}, 34'hFF);
        tally_and_finish();
    end
endmodule : spi_slave_select_sync_bench
